/* File: pfcs_map.svh */
// Purpose: constants for the parallel flash command/status host controller
// Assumes: 20 MHz sys_clk, 50 ns period
// Notes:   times in ns; cycle counts derived from them
`ifndef PFCS_MAP_SVH
`define PFCS_MAP_SVH

`define PFCS_CLK_NS           50
// least times round up, at least one cycle
`define PFCS_CYC_MIN(ns)      ((((ns) + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS) < 1 ? 1 : \
	(((ns) + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS))
`define PFCS_WP_NS            200
`define PFCS_WPH_NS           200
`define PFCS_AH_NS            100
`define PFCS_DS_NS            100
`define PFCS_STROBE_HIGH_PULSE_MIN_NS 150
`define PFCS_ACC_NS           150
`define PFCS_WP_CYC           `PFCS_CYC_MIN(`PFCS_WP_NS)
`define PFCS_WPH_CYC          `PFCS_CYC_MIN(`PFCS_WPH_NS)
`define PFCS_DS_CYC           `PFCS_CYC_MIN(`PFCS_DS_NS)
`define PFCS_OEHP_CYC         `PFCS_CYC_MIN(`PFCS_STROBE_HIGH_PULSE_MIN_NS)
`define PFCS_ACC_CYC          `PFCS_CYC_MIN(`PFCS_ACC_NS)
`define PFCS_TOGGLE_BIT       6
`define PFCS_CMD_ADDR_W       15
`define PFCS_SEQ_MAX          6
`define PFCS_BOOT_LO          17'h00000
`define PFCS_BOOT_HI          17'h01fff
// operation codes on op_code
`define PFCS_OP_READ          3'h0
`define PFCS_OP_PROG          3'h1
`define PFCS_OP_ERASE         3'h2
`define PFCS_OP_ID_ENTRY      3'h3
`define PFCS_OP_ID_EXIT       3'h4
`define PFCS_OP_LOCKOUT       3'h5

`endif

/* File: pfcs_pkg.sv */
// Purpose: types for the parallel flash command/status host controller
// Assumes: nothing beyond the map header
// Notes:   pin bundle carries all flash strobes
`default_nettype none
package pfcs_pkg;
	typedef struct packed {
		logic [16:0] addr;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [7:0]  dq_out;
		logic        dq_oe;
	} pfcs_pins_t;

	typedef struct packed {
		logic [14:0] addr;
		logic [7:0]  data;
	} pfcs_cmd_t;

	typedef enum logic [3:0] {
		PF_IDLE, PF_W_SETUP, PF_W_LOW, PF_W_HIGH, PF_R_LOW, PF_R_HIGH,
		PF_P_READ, PF_P_HIGH, PF_DONE
	} pfcs_state_t;
endpackage
`default_nettype wire

/* File: pfcs_host.sv */
// Purpose: host side sequencer driving a byte-wide parallel flash
// Assumes: command tables come in through cmd_table; 20 MHz clock
// Notes:   one op at a time; busy until done pulses
`include "pfcs_map.svh"
`default_nettype none
module pfcs_host
	import pfcs_pkg::*;
#(
	parameter int SEQ_MAX = `PFCS_SEQ_MAX
) (
	input  wire logic                      sys_clk,
	input  wire logic                      reset_n,
	input  wire logic                      op_valid,
	input  wire logic [2:0]                op_code,
	input  wire logic [16:0]               op_addr,
	input  wire logic [7:0]                op_data,
	input  wire logic [2:0]                cmd_len,
	input  wire pfcs_cmd_t [SEQ_MAX-1:0]   cmd_table,
	input  wire logic [7:0]                dq_in,
	output var  pfcs_pins_t                pins_q,
	output logic                           busy_q,
	output logic                           done_q,
	output logic [7:0]                     rdata_q,
	output logic                           id_mode_q,
	output logic                           boot_locked_q,
	output logic                           boot_hit_q
);
	pfcs_state_t state_q;
	logic [7:0]  cnt_q;
	logic [2:0]  idx_q;
	logic [2:0]  op_q;
	logic [16:0] addr_q;
	logic [7:0]  data_q;
	logic [2:0]  len_q;
	logic [7:0]  dq_s1_q;
	logic [7:0]  dq_s2_q;
	logic        prev_tog_q;
	logic        have_prev_q;
	logic        poll_op;
	logic        seq_left;

	// pins come from the flash, outside this domain
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dq_s1_q <= 8'h00;
			dq_s2_q <= 8'h00;
		end else begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	assign poll_op  = (op_q == `PFCS_OP_PROG) || (op_q == `PFCS_OP_ERASE);
	assign seq_left = (idx_q < len_q);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= PF_IDLE;
			cnt_q       <= 8'h00;
			idx_q       <= 3'h0;
			op_q        <= `PFCS_OP_READ;
			addr_q      <= 17'h00000;
			data_q      <= 8'h00;
			len_q       <= 3'h0;
			pins_q      <= '{addr: 17'h00000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				dq_out: 8'h00, dq_oe: 1'b0};
			busy_q      <= 1'b0;
			done_q      <= 1'b0;
			rdata_q     <= 8'h00;
			prev_tog_q  <= 1'b0;
			have_prev_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				PF_IDLE: begin
					if (op_valid) begin
						op_q   <= op_code;
						addr_q <= op_addr;
						data_q <= op_data;
						len_q  <= (op_code == `PFCS_OP_READ) ? 3'h0 : cmd_len;
						idx_q  <= 3'h0;
						busy_q <= 1'b1;
						cnt_q  <= 8'h00;
						state_q <= (op_code == `PFCS_OP_READ) ? PF_R_LOW : PF_W_SETUP;
					end
				end
				PF_W_SETUP: begin
					// table bytes first, then the programmed byte itself
					if (seq_left) begin
						pins_q.addr   <= {2'b00, cmd_table[idx_q].addr};
						pins_q.dq_out <= cmd_table[idx_q].data;
					end else begin
						pins_q.addr   <= addr_q;
						pins_q.dq_out <= data_q;
					end
					pins_q.dq_oe <= 1'b1;
					pins_q.oe_n  <= 1'b1;
					pins_q.ce_n  <= 1'b0;
					cnt_q   <= 8'h00;
					state_q <= PF_W_LOW;
				end
				PF_W_LOW: begin
					pins_q.we_n <= 1'b0;
					pins_q.oe_n <= 1'b1;
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q >= 8'(`PFCS_WP_CYC)) begin
						pins_q.we_n <= 1'b1;
						cnt_q   <= 8'h00;
						state_q <= PF_W_HIGH;
					end
				end
				PF_W_HIGH: begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q >= 8'(`PFCS_WPH_CYC)) begin
						pins_q.ce_n  <= 1'b1;
						pins_q.dq_oe <= 1'b0;
						idx_q <= idx_q + 3'h1;
						cnt_q <= 8'h00;
						if (idx_q + 3'h1 < len_q || (idx_q + 3'h1 == len_q && op_q ==
							`PFCS_OP_PROG)) begin
							state_q <= PF_W_SETUP;
						end else if (poll_op) begin
							pins_q.addr <= addr_q;
							have_prev_q <= 1'b0;
							state_q     <= PF_P_READ;
						end else begin
							state_q <= PF_DONE;
						end
					end
				end
				PF_R_LOW: begin
					pins_q.addr <= addr_q;
					pins_q.ce_n <= 1'b0;
					pins_q.oe_n <= 1'b0;
					cnt_q <= cnt_q + 8'h01;
					// two extra cycles cover the input synchroniser
					if (cnt_q >= 8'(`PFCS_ACC_CYC + 2)) begin
						rdata_q     <= dq_s2_q;
						pins_q.ce_n <= 1'b1;
						pins_q.oe_n <= 1'b1;
						state_q     <= PF_DONE;
					end
				end
				PF_P_READ: begin
					pins_q.ce_n <= 1'b0;
					pins_q.oe_n <= 1'b0;
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q >= 8'(`PFCS_ACC_CYC + 2)) begin
						pins_q.oe_n <= 1'b1;
						pins_q.ce_n <= 1'b1;
						cnt_q       <= 8'h00;
						prev_tog_q  <= dq_s2_q[`PFCS_TOGGLE_BIT];
						have_prev_q <= 1'b1;
						rdata_q     <= dq_s2_q;
						// no assumed start value: compare with previous read only
						if (have_prev_q && prev_tog_q == dq_s2_q[`PFCS_TOGGLE_BIT]) begin
							state_q <= PF_DONE;
						end else begin
							state_q <= PF_P_HIGH;
						end
					end
				end
				PF_P_HIGH: begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q >= 8'(`PFCS_OEHP_CYC)) begin
						cnt_q   <= 8'h00;
						state_q <= PF_P_READ;
					end
				end
				PF_DONE: begin
					busy_q  <= 1'b0;
					done_q  <= 1'b1;
					state_q <= PF_IDLE;
				end
				default: state_q <= PF_IDLE;
			endcase
		end
	end

	// device state mirror; id mode is lost with device power host resets it
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			id_mode_q     <= 1'b0;
			boot_locked_q <= 1'b0;
		end else if (state_q == PF_DONE) begin
			if (op_q == `PFCS_OP_ID_ENTRY)
				id_mode_q <= 1'b1;
			else if (op_q == `PFCS_OP_ID_EXIT)
				id_mode_q <= 1'b0;
			if (op_q == `PFCS_OP_LOCKOUT)
				boot_locked_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			boot_hit_q <= 1'b0;
		else if (op_valid && state_q == PF_IDLE)
			boot_hit_q <= (op_addr <= `PFCS_BOOT_HI);
	end
endmodule
`default_nettype wire

/* File: pfcs_assertions.sv */
// Purpose: port property checks for the flash host
// Assumes: one clock, async active-low reset
// Notes:   bound into pfcs_host
`include "pfcs_map.svh"
`default_nettype none
module pfcs_assertions
	import pfcs_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        op_valid,
	input wire logic [2:0]  op_code,
	input wire logic [16:0] op_addr,
	input wire pfcs_pins_t  pins_q,
	input wire logic        busy_q,
	input wire logic        done_q,
	input wire logic        id_mode_q,
	input wire logic        boot_locked_q,
	input wire logic        boot_hit_q
);
	logic [2:0] op_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			op_q <= 3'h0;
		else if (op_valid && !busy_q)
			op_q <= op_code;
	end
	chk_erase_oe_high: assert property (!pins_q.we_n && !pins_q.ce_n |-> pins_q.oe_n)
		else $error("oe low in write pulse");
	chk_poll_gap_min: assert property (busy_q && $rose(pins_q.oe_n) |-> pins_q.oe_n[*3])
		else $error("strobe high too short");
	chk_poll_addr_hold: assert property (
		!pins_q.oe_n && !$past(pins_q.oe_n) |-> $stable(pins_q.addr))
		else $error("address moved in read");
	chk_write_drives: assert property (!pins_q.we_n |-> pins_q.dq_oe)
		else $error("write without data");
	chk_boot_hit_cmp: assert property (
		op_valid && !busy_q |=> boot_hit_q == ($past(op_addr) <= `PFCS_BOOT_HI))
		else $error("boot hit wrong");
	chk_id_entry_set: assert property (
		$rose(done_q) && op_q == `PFCS_OP_ID_ENTRY |-> ##[0:2] id_mode_q)
		else $error("id mode not set");
	chk_id_exit_clr: assert property (
		$rose(done_q) && op_q == `PFCS_OP_ID_EXIT |-> ##[0:2] !id_mode_q)
		else $error("id mode not cleared");
	chk_lockout_set: assert property (
		$rose(done_q) && op_q == `PFCS_OP_LOCKOUT |-> ##[0:2] boot_locked_q)
		else $error("lockout not set");
	cover property ($rose(done_q) && op_q == `PFCS_OP_ERASE);
	cover property ($rose(done_q) && op_q == `PFCS_OP_PROG);
	cover property ($rose(done_q) && op_q == `PFCS_OP_LOCKOUT);
endmodule
bind pfcs_host pfcs_assertions chk_u (
	.sys_clk       (sys_clk),
	.reset_n       (reset_n),
	.op_valid      (op_valid),
	.op_code       (op_code),
	.op_addr       (op_addr),
	.pins_q        (pins_q),
	.busy_q        (busy_q),
	.done_q        (done_q),
	.id_mode_q     (id_mode_q),
	.boot_locked_q (boot_locked_q),
	.boot_hit_q    (boot_hit_q)
);
`default_nettype wire

/* File: pfcs_flash_model.sv */
// Purpose: behavioural byte-wide flash for the host bench
// Assumes: command codes chosen by the bench tables
// Notes:   released bus shows inverse of last byte
`default_nettype none
module pfcs_flash_model
	import pfcs_pkg::*;
#(
	parameter logic [7:0] MAN_ID = 8'h3c, // arbitrary
	parameter logic [7:0] DEV_ID = 8'hc3  // arbitrary
) (
	input  wire pfcs_pins_t pins,
	output var logic [7:0]  dq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [int];
	logic [7:0] last = 8'h00;
	logic       tog = 1'b0;
	logic       id = 1'b0;
	logic       lock = 1'b0;
	logic       pgm = 1'b0;
	int         busy = 0;
	int         ev = 0;
	always @(posedge pins.we_n) if (!pins.ce_n) begin
		if (pgm) begin
			if (!(lock && pins.addr <= 17'h01fff))
				mem[pins.addr] = pins.dq_out;
			pgm = 0;
			busy = 3;
		end else case (pins.dq_out)
			8'ha0: pgm = 1;
			8'h10: begin
				mem.delete();
				busy = 4;
			end
			8'h90: id = 1;
			8'hf0: id = 0;
			8'h40: lock = 1;
			default: ;
		endcase
		ev++;
	end
	always @(posedge (pins.ce_n | pins.oe_n)) if (busy > 0) begin
		tog = !tog;
		busy--;
		ev++;
	end
	always @(pins or ev) begin
		if (pins.ce_n || pins.oe_n)
			dq = ~last;
		else begin
			if (id && pins.addr[16:1] == 16'h0000)
				dq = pins.addr[0] ? DEV_ID : MAN_ID;
			else if (busy > 0)
				dq = {1'b0, tog, 6'h15};
			else
				dq = mem.exists(pins.addr) ? mem[pins.addr] : 8'hff;
			last = dq;
		end
	end
endmodule
`default_nettype wire

/* File: parallel_flash_command_status_bench.sv */
// Purpose: self-checking bench for the flash host
// Assumes: flash model on the pins
// Notes:   inputs change on falling edge
`include "pfcs_map.svh"
`default_nettype none
module parallel_flash_command_status_bench
	import pfcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] MAN_ID = 8'h3c; // arbitrary
	localparam logic [7:0] DEV_ID = 8'hc3; // arbitrary
	logic            sys_clk = 0, reset_n = 0, op_valid = 0;
	logic            busy_q, done_q, id_mode_q, boot_locked_q, boot_hit_q;
	logic [2:0]      op_code = 0, cmd_len = 0;
	logic [16:0]     op_addr = 0;
	logic [7:0]      op_data = 0, dq_in, rdata_q;
	pfcs_cmd_t [5:0] cmd_table = '0;
	pfcs_pins_t      pins_q;
	int              fail_count = 0, tests_run = 0, cycles = 0;
	always #25 sys_clk = ~sys_clk;
	pfcs_host dut_u (
		.sys_clk       (sys_clk),
		.reset_n       (reset_n),
		.op_valid      (op_valid),
		.op_code       (op_code),
		.op_addr       (op_addr),
		.op_data       (op_data),
		.cmd_len       (cmd_len),
		.cmd_table     (cmd_table),
		.dq_in         (dq_in),
		.pins_q        (pins_q),
		.busy_q        (busy_q),
		.done_q        (done_q),
		.rdata_q       (rdata_q),
		.id_mode_q     (id_mode_q),
		.boot_locked_q (boot_locked_q),
		.boot_hit_q    (boot_hit_q)
	);
	pfcs_flash_model #(.MAN_ID(MAN_ID), .DEV_ID(DEV_ID)) flash_u (.pins(pins_q), .dq(dq_in));
	task finish_test;
		$display("mismatches %0d of %0d checks", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge sys_clk) if (++cycles == 20000) begin
		fail_count++;
		finish_test;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// command table: fillers, then the code byte last
	task run(input logic [2:0] c, input logic [16:0] a, input logic [7:0] d, code, input int n);
		int i;
		@(negedge sys_clk);
		for (i = 0; i < n; i++)
			cmd_table[i] = {15'h0555 + 15'(i), i == n - 1 ? code : 8'h11};
		op_code = c;
		op_addr = a;
		op_data = d;
		cmd_len = 3'(n);
		op_valid = 1;
		@(negedge sys_clk);
		op_valid = 0;
		for (i = 0; i < 2000 && done_q !== 1'b1; i++)
			@(negedge sys_clk);
		// a stuck op counts here rather than passing on stale outputs
		chk({6'h00, busy_q, done_q}, 8'h01);
	endtask
	task t_program;
		run(0, 17'h02100, 0, 0, 0);
		chk(rdata_q, 8'hff);
		chk({7'h0, boot_hit_q}, 8'h00);
		run(1, 17'h02100, 8'h5a, 8'ha0, 1);
		chk(rdata_q, 8'h5a);
		run(0, 17'h02100, 0, 0, 0);
		chk(rdata_q, 8'h5a);
	endtask
	task t_ident;
		run(3, 0, 0, 8'h90, 2);
		chk({7'h0, id_mode_q}, 8'h01);
		run(0, 0, 0, 0, 0);
		chk(rdata_q, MAN_ID);
		run(0, 1, 0, 0, 0);
		chk(rdata_q, DEV_ID);
		run(4, 0, 0, 8'hf0, 1);
		chk({7'h0, id_mode_q}, 8'h00);
		run(0, 17'h02100, 0, 0, 0);
		chk(rdata_q, 8'h5a);
	endtask
	task t_erase;
		run(2, 17'h02100, 0, 8'h10, 2);
		run(0, 17'h02100, 0, 0, 0);
		chk(rdata_q, 8'hff);
	endtask
	task t_lock;
		run(5, 0, 0, 8'h40, 3);
		chk({7'h0, boot_locked_q}, 8'h01);
		run(1, 17'h00010, 8'h00, 8'ha0, 1);
		chk({7'h0, boot_hit_q}, 8'h01);
		run(0, 17'h00010, 0, 0, 0);
		chk(rdata_q, 8'hff);
	endtask
	initial begin
		repeat (8) @(negedge sys_clk);
		reset_n = 1;
		t_program;
		t_ident;
		t_erase;
		t_lock;
		finish_test;
	end
endmodule
`default_nettype wire
